// ---- hw/rtctk_pkg.sv ----
// Constants for the timekeeping core: register offsets, field positions,
// reset values and divider figures.
// Assumes a 250 MHz system clock and a 32.768 kHz crystal arriving on a pin.
package rtctk_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] RTCTK_OFS_CONTROL = 8'h00;
    localparam logic [7:0] RTCTK_OFS_CALIB = 8'h01;
    localparam logic [7:0] RTCTK_OFS_SECONDS = 8'h02;
    localparam logic [7:0] RTCTK_OFS_MINUTES = 8'h03;
    localparam logic [7:0] RTCTK_OFS_HOURS = 8'h04;
    localparam logic [7:0] RTCTK_OFS_WEEKDAY = 8'h05;
    localparam logic [7:0] RTCTK_OFS_DATE = 8'h06;
    localparam logic [7:0] RTCTK_OFS_MONTH = 8'h07;
    localparam logic [7:0] RTCTK_OFS_YEAR = 8'h08;
    localparam logic [7:0] RTCTK_OFS_CONFIG = 8'h0B;
    localparam int RTCTK_TIME_REGS = 7;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int RTCTK_CTL_READ_BIT = 0;
    localparam int RTCTK_CTL_WRITE_BIT = 1;
    localparam int RTCTK_CTL_CAL_BIT = 2;
    localparam int RTCTK_CFG_TRICKLE_BIT = 2;
    localparam int RTCTK_CAL_SIGN_BIT = 5;
    localparam int RTCTK_CAL_MAG_W = 5;
    localparam int RTCTK_CAL_W = 6;
    localparam int RTCTK_TONE_BIT = 5;

    // ------------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------------
    localparam logic [7:0] RTCTK_CONTROL_RST = 8'h00;
    localparam logic [7:0] RTCTK_CONFIG_RST = 8'h00;
    localparam logic [7:0] RTCTK_CONFIG_MASK = 8'h7F;
    localparam logic [7:0] RTCTK_CONTROL_MASK = 8'h07;

    // ------------------------------------------------------------------
    // Time base: crystal edges per second
    // ------------------------------------------------------------------
    localparam int RTCTK_XTAL_HZ = 32768;
    localparam int RTCTK_DIV_W = 15;
    localparam logic [14:0] RTCTK_DIV_LAST = 15'(RTCTK_XTAL_HZ - 1);

    // ------------------------------------------------------------------
    // Calendar limits, packed BCD
    // ------------------------------------------------------------------
    localparam logic [7:0] RTCTK_SEC_MAX = 8'h59;
    localparam logic [7:0] RTCTK_MIN_MAX = 8'h59;
    localparam logic [7:0] RTCTK_HOUR_MAX = 8'h23;
    localparam logic [7:0] RTCTK_DOW_MAX = 8'h07;
    localparam logic [7:0] RTCTK_MON_MAX = 8'h12;
    localparam logic [7:0] RTCTK_YEAR_MAX = 8'h99;
    localparam logic [7:0] RTCTK_ZERO = 8'h00;
    localparam logic [7:0] RTCTK_ONE = 8'h01;
    localparam logic [7:0] RTCTK_MON_FEB = 8'h02;
    localparam logic [7:0] RTCTK_MON_APR = 8'h04;
    localparam logic [7:0] RTCTK_MON_JUN = 8'h06;
    localparam logic [7:0] RTCTK_MON_SEP = 8'h09;
    localparam logic [7:0] RTCTK_MON_NOV = 8'h11;
    localparam logic [7:0] RTCTK_DAYS_28 = 8'h28;
    localparam logic [7:0] RTCTK_DAYS_29 = 8'h29;
    localparam logic [7:0] RTCTK_DAYS_30 = 8'h30;
    localparam logic [7:0] RTCTK_DAYS_31 = 8'h31;

endpackage

// ---- hw/rtctk_core.sv ----
// Timekeeping core with user holding registers, read snapshot, write lock,
// digital calibration, calibration tone output and trickle-charge control.
// Assumes a register port already decoded from the two-wire serial bus on
// the CLK domain, and crystal, comparator and supply-low levels on pins.
//
// Function
// - Divide crystal down to one-second tick
// - Time and date user registers, read/write
// - Read bit rising copies core to holding
// - Pending tick completes before snapshot copy
// - Holding registers frozen while read bit set
// - Write bit holds host time writes
// - Write bit clearing loads core from user
// - Core advances every tick unless locked
// - Timekeeping continues on backup when supply low
// - Trickle bit drives backup charge enable
// - Calibration bit takes over shared pin
// - Calibration mode outputs 512 Hz square wave
// - Sign adds pulses, else removes pulses
// - Magnitude in bits 4:0, kept nonvolatile
// - Calibration writes only in calibration mode
// - Calibration bit clear restores power-fail output
// - Calibration bit is control bit 2
// - Six-bit value, sign above magnitude
`timescale 1ns/1ps
`default_nettype none

module rtctk_core #(
    // Crystal edges per second; a bench may cut it to shorten the second
    parameter int XTAL_HZ = rtctk_pkg::RTCTK_XTAL_HZ
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic XTAL_IN,
    input wire logic POWERFAIL_CMP_N,
    input wire logic VDD_LOW,
    input wire logic [rtctk_pkg::RTCTK_CAL_W-1:0] NV_CAL_VALUE,
    output logic NV_CAL_WR,
    output logic [rtctk_pkg::RTCTK_CAL_W-1:0] NV_CAL_DATA,
    output logic TUNING_OR_POWERFAIL_OUT,
    output logic TRICKLE_CHARGE_ENABLE,
    output logic BACKUP_SUPPLY_SELECT
);
    import rtctk_pkg::*;

    // ------------------------------------------------------------------
    // Divider figures
    // ------------------------------------------------------------------
    // The tone taps one divider bit, so a second must hold whole tone
    // periods, and up to 31 edges may be gained or skipped within it.
    localparam int TONE_EDGES = 2 << RTCTK_TONE_BIT;
    localparam logic [RTCTK_DIV_W-1:0] DIV_LAST = RTCTK_DIV_W'(XTAL_HZ - 1);

    generate
        if ((XTAL_HZ < 2 * TONE_EDGES) || (XTAL_HZ % TONE_EDGES != 0)
            || (XTAL_HZ > (1 << RTCTK_DIV_W))) begin : g_bad_rate
            $error("Crystal rate does not suit the divider");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] xtal_sync_r;
    logic xtal_prev_r;
    logic [1:0] pfo_sync_r;
    logic [1:0] vlow_sync_r;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            xtal_sync_r <= 2'h0;
            xtal_prev_r <= 1'b0;
            pfo_sync_r <= 2'h3;
            vlow_sync_r <= 2'h0;
        end else begin
            xtal_sync_r <= {xtal_sync_r[0], XTAL_IN};
            xtal_prev_r <= xtal_sync_r[1];
            pfo_sync_r <= {pfo_sync_r[0], POWERFAIL_CMP_N};
            vlow_sync_r <= {vlow_sync_r[0], VDD_LOW};
        end
    end

    wire xtal_edge = xtal_sync_r[1] & ~xtal_prev_r;

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    logic [7:0] control_r;
    logic [7:0] config_r;
    logic [RTCTK_CAL_W-1:0] cal_r;
    logic cal_loaded_r;
    logic [7:0] user_r [RTCTK_TIME_REGS];
    logic [7:0] core_r [RTCTK_TIME_REGS];
    logic [7:0] core_nxt [RTCTK_TIME_REGS];

    // Host access is locked out while main supply is low
    wire bus_ok = ~vlow_sync_r[1];
    wire wr_ok = REG_WR & bus_ok;
    wire wr_control = wr_ok && (REG_ADDR == RTCTK_OFS_CONTROL);
    wire wr_config = wr_ok && (REG_ADDR == RTCTK_OFS_CONFIG);
    wire wr_cal = wr_ok && (REG_ADDR == RTCTK_OFS_CALIB)
                  && control_r[RTCTK_CTL_CAL_BIT];
    wire time_hit = (REG_ADDR >= RTCTK_OFS_SECONDS) && (REG_ADDR <= RTCTK_OFS_YEAR);
    wire [7:0] time_idx = REG_ADDR - RTCTK_OFS_SECONDS;

    wire read_bit = control_r[RTCTK_CTL_READ_BIT];
    wire lock_bit = control_r[RTCTK_CTL_WRITE_BIT];
    wire read_new = REG_WDATA[RTCTK_CTL_READ_BIT];
    wire lock_new = REG_WDATA[RTCTK_CTL_WRITE_BIT];
    // Snapshot takes next-state values so a tick in flight is not lost
    wire snap_go = wr_control & read_new & ~read_bit;
    wire load_go = wr_control & ~lock_new & lock_bit;

    // ------------------------------------------------------------------
    // Control, configuration and calibration registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            control_r <= RTCTK_CONTROL_RST;
            config_r <= RTCTK_CONFIG_RST;
        end else begin
            if (wr_control) begin
                control_r <= REG_WDATA & RTCTK_CONTROL_MASK;
            end
            if (wr_config) begin
                config_r <= REG_WDATA & RTCTK_CONFIG_MASK;
            end
        end
    end

    // The correction lives in external nonvolatile storage: it is fetched
    // once after reset and every accepted write is echoed back to it.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cal_r <= '0;
            cal_loaded_r <= 1'b0;
            NV_CAL_WR <= 1'b0;
            NV_CAL_DATA <= '0;
        end else begin
            cal_loaded_r <= 1'b1;
            NV_CAL_WR <= wr_cal;
            if (!cal_loaded_r) begin
                cal_r <= NV_CAL_VALUE;
            end else if (wr_cal) begin
                cal_r <= REG_WDATA[RTCTK_CAL_W-1:0];
                NV_CAL_DATA <= REG_WDATA[RTCTK_CAL_W-1:0];
            end
        end
    end

    wire cal_sign = cal_r[RTCTK_CAL_SIGN_BIT];
    wire [RTCTK_CAL_MAG_W-1:0] cal_mag = cal_r[RTCTK_CAL_MAG_W-1:0];

    // ------------------------------------------------------------------
    // Corrected divider chain
    // ------------------------------------------------------------------
    // Once a second the divider is either preloaded with the magnitude,
    // gaining that many crystal edges, or made to skip that many edges.
    logic [RTCTK_DIV_W-1:0] div_r;
    logic [RTCTK_CAL_MAG_W-1:0] skip_r;
    logic sec_tick_r;

    wire div_wrap = xtal_edge && (skip_r == '0) && (div_r == DIV_LAST);
    wire [RTCTK_DIV_W-1:0] div_seed = cal_sign ? RTCTK_DIV_W'(cal_mag) : '0;
    wire [RTCTK_CAL_MAG_W-1:0] skip_seed = cal_sign ? '0 : cal_mag;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            div_r <= '0;
            skip_r <= '0;
            sec_tick_r <= 1'b0;
        end else begin
            sec_tick_r <= div_wrap;
            if (xtal_edge) begin
                if (skip_r != '0) begin
                    skip_r <= skip_r - 1'b1;
                end else if (div_wrap) begin
                    div_r <= div_seed;
                    skip_r <= skip_seed;
                end else begin
                    div_r <= div_r + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Calendar arithmetic in packed BCD
    // ------------------------------------------------------------------
    function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                            input logic [7:0] first);
        if (v >= last) begin
            bcd_step = first;
        end else if (v[3:0] >= 4'h9) begin
            bcd_step = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_step = v + 8'h01;
        end
    endfunction

    // Year 00 counts as leap, matching the 2000 to 2099 span
    function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        if (mon == RTCTK_MON_FEB) begin
            month_days = leap ? RTCTK_DAYS_29 : RTCTK_DAYS_28;
        end else if (mon == RTCTK_MON_APR || mon == RTCTK_MON_JUN
                     || mon == RTCTK_MON_SEP || mon == RTCTK_MON_NOV) begin
            month_days = RTCTK_DAYS_30;
        end else begin
            month_days = RTCTK_DAYS_31;
        end
    endfunction

    // Ticks that arrive while locked are dropped, not queued
    wire advance = sec_tick_r & ~lock_bit;
    wire [7:0] last_day = month_days(core_r[5], core_r[6]);
    wire c_min = advance && (core_r[0] == RTCTK_SEC_MAX);
    wire c_hour = c_min && (core_r[1] == RTCTK_MIN_MAX);
    wire c_day = c_hour && (core_r[2] == RTCTK_HOUR_MAX);
    wire c_mon = c_day && (core_r[4] >= last_day);
    wire c_year = c_mon && (core_r[5] == RTCTK_MON_MAX);

    always_comb begin
        for (int i = 0; i < RTCTK_TIME_REGS; i++) begin
            core_nxt[i] = core_r[i];
        end
        if (advance) begin
            core_nxt[0] = bcd_step(core_r[0], RTCTK_SEC_MAX, RTCTK_ZERO);
        end
        if (c_min) begin
            core_nxt[1] = bcd_step(core_r[1], RTCTK_MIN_MAX, RTCTK_ZERO);
        end
        if (c_hour) begin
            core_nxt[2] = bcd_step(core_r[2], RTCTK_HOUR_MAX, RTCTK_ZERO);
        end
        if (c_day) begin
            core_nxt[3] = bcd_step(core_r[3], RTCTK_DOW_MAX, RTCTK_ONE);
            core_nxt[4] = bcd_step(core_r[4], last_day, RTCTK_ONE);
        end
        if (c_mon) begin
            core_nxt[5] = bcd_step(core_r[5], RTCTK_MON_MAX, RTCTK_ONE);
        end
        if (c_year) begin
            core_nxt[6] = bcd_step(core_r[6], RTCTK_YEAR_MAX, RTCTK_ZERO);
        end
    end

    // ------------------------------------------------------------------
    // Core and user time registers
    // ------------------------------------------------------------------
    // Day of week, date and month start at one so the calendar is legal.
    generate
        for (genvar g = 0; g < RTCTK_TIME_REGS; g++) begin : g_time
            localparam logic [7:0] INIT = (g >= 3 && g <= 5) ? RTCTK_ONE : RTCTK_ZERO;
            wire user_hit = wr_ok && time_hit && (time_idx == 8'(g));

            always_ff @(posedge CLK or posedge RESET) begin
                if (RESET) begin
                    core_r[g] <= INIT;
                    user_r[g] <= INIT;
                end else begin
                    // Host must not load out-of-range values here
                    if (load_go) begin
                        core_r[g] <= user_r[g];
                    end else begin
                        core_r[g] <= core_nxt[g];
                    end
                    // A host write wins over a snapshot in the same cycle
                    if (user_hit) begin
                        user_r[g] <= REG_WDATA;
                    end else if (snap_go) begin
                        user_r[g] <= core_nxt[g];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read-back and pin outputs
    // ------------------------------------------------------------------
    wire [7:0] time_rd = user_r[time_idx[2:0]];
    wire [7:0] rd_mux = (REG_ADDR == RTCTK_OFS_CONTROL) ? control_r :
                        (REG_ADDR == RTCTK_OFS_CALIB) ? {2'h0, cal_r} :
                        (REG_ADDR == RTCTK_OFS_CONFIG) ? config_r :
                        time_hit ? time_rd : 8'h00;

    wire cal_mode = control_r[RTCTK_CTL_CAL_BIT];
    wire tone = div_r[RTCTK_TONE_BIT];
    wire shared_pin = cal_mode ? tone : pfo_sync_r[1];

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            REG_RDATA <= 8'h00;
            TUNING_OR_POWERFAIL_OUT <= 1'b1;
            TRICKLE_CHARGE_ENABLE <= 1'b0;
            BACKUP_SUPPLY_SELECT <= 1'b0;
        end else begin
            if (REG_RD && bus_ok) begin
                REG_RDATA <= rd_mux;
            end
            TUNING_OR_POWERFAIL_OUT <= shared_pin;
            TRICKLE_CHARGE_ENABLE <= config_r[RTCTK_CFG_TRICKLE_BIT];
            BACKUP_SUPPLY_SELECT <= vlow_sync_r[1];
        end
    end

endmodule

`default_nettype wire

// ---- verification/rtctk_core_assertions.sv ----
// Port-level checker for the timekeeping core.
// Assumes no host write within a few cycles of a supply-low change.
`timescale 1ns/1ps
`default_nettype none

module rtctk_core_assertions (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic POWERFAIL_CMP_N,
    input wire logic VDD_LOW,
    input wire logic NV_CAL_WR,
    input wire logic [rtctk_pkg::RTCTK_CAL_W-1:0] NV_CAL_DATA,
    input wire logic TUNING_OR_POWERFAIL_OUT,
    input wire logic TRICKLE_CHARGE_ENABLE,
    input wire logic BACKUP_SUPPLY_SELECT
);
    import rtctk_pkg::*;

    // ----
    // Mirror of mode bits, fed from host writes
    // ----
    logic cal_r;
    logic trk_r;
    logic wr_ctl;
    logic wr_cal;
    logic wr_cfg;
    assign wr_ctl = REG_WR && !VDD_LOW && !BACKUP_SUPPLY_SELECT && REG_ADDR == RTCTK_OFS_CONTROL;
    assign wr_cal = REG_WR && REG_ADDR == RTCTK_OFS_CALIB;
    assign wr_cfg = REG_WR && !VDD_LOW && !BACKUP_SUPPLY_SELECT && REG_ADDR == RTCTK_OFS_CONFIG;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cal_r <= 1'h0;
            trk_r <= 1'h0;
        end else begin
            if (wr_ctl)
                cal_r <= REG_WDATA[RTCTK_CTL_CAL_BIT];
            if (wr_cfg)
                trk_r <= REG_WDATA[RTCTK_CFG_TRICKLE_BIT];
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // ----
    // Properties
    // ----
    chk_trickle_src: assert property (
        $changed(TRICKLE_CHARGE_ENABLE) |-> TRICKLE_CHARGE_ENABLE == trk_r
            && ($past(wr_cfg) || $past(wr_cfg, 2)))
        else $error("trickle enable moved without a config write");
    chk_backup_follow: assert property (
        $changed(VDD_LOW) ##1 $stable(VDD_LOW) [*5] |-> BACKUP_SUPPLY_SELECT == VDD_LOW)
        else $error("backup select does not follow supply low");
    chk_rdata_hold: assert property (
        $changed(REG_RDATA) |-> $past(REG_RD))
        else $error("read data changed without a read");
    chk_nv_source: assert property (
        NV_CAL_WR |-> $past(wr_cal && cal_r)
            && NV_CAL_DATA == $past(REG_WDATA[RTCTK_CAL_W-1:0]))
        else $error("calibration store pulse without legal write");
    chk_cal_gate: assert property (
        wr_cal && !VDD_LOW && !BACKUP_SUPPLY_SELECT |=> NV_CAL_WR == $past(cal_r))
        else $error("calibration write gating wrong");
    chk_pfo_follow: assert property (
        (!cal_r && $stable(POWERFAIL_CMP_N)) [*6] |-> TUNING_OR_POWERFAIL_OUT == POWERFAIL_CMP_N)
        else $error("shared pin does not show comparator");
    // Tone half period spans many crystal edges, so no quick flips
    chk_tone_steady: assert property (
        cal_r && $changed(TUNING_OR_POWERFAIL_OUT)
            |=> (!cal_r || $stable(TUNING_OR_POWERFAIL_OUT)) [*8])
        else $error("shared pin glitches in calibration mode");
    chk_lowv_refuse: assert property (
        VDD_LOW [*5] ##0 REG_RD |=> $stable(REG_RDATA))
        else $error("read accepted while supply low");

    cov_cal_write: cover property (NV_CAL_WR);
    cov_tone_edge: cover property (cal_r && $changed(TUNING_OR_POWERFAIL_OUT));
    cov_trickle_on: cover property ($rose(TRICKLE_CHARGE_ENABLE));
endmodule

bind rtctk_core rtctk_core_assertions u_chk (.CLK, .RESET, .REG_ADDR, .REG_WDATA,
    .REG_WR, .REG_RD, .REG_RDATA, .POWERFAIL_CMP_N, .VDD_LOW, .NV_CAL_WR,
    .NV_CAL_DATA, .TUNING_OR_POWERFAIL_OUT, .TRICKLE_CHARGE_ENABLE,
    .BACKUP_SUPPLY_SELECT);
`default_nettype wire

// ---- verification/rtctk_host.sv ----
// Host model: register-port master with one-cycle strobes.
// Assumes one caller at a time; idle lines carry the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none

module rtctk_host (
    input wire logic CLK,
    input wire logic [7:0] REG_RDATA,
    output logic [7:0] REG_ADDR,
    output logic [7:0] REG_WDATA,
    output logic REG_WR,
    output logic REG_RD
);
    initial begin
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WR = 1'h0;
        REG_RD = 1'h0;
    end

    task automatic drop();
        REG_WR = 1'h0;
        REG_RD = 1'h0;
        REG_ADDR = ~REG_ADDR;
        REG_WDATA = ~REG_WDATA;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        #1;
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'h1;
        @(posedge CLK);
        #1;
        drop();
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK);
        #1;
        REG_ADDR = a;
        REG_RD = 1'h1;
        @(posedge CLK);
        #1;
        drop();
        d = REG_RDATA;
    endtask
endmodule
`default_nettype wire

// ---- verification/rtctk_core_tb.sv ----
// Self-checking bench for the timekeeping core.
// Assumes the host model; the crystal rate is cut to 128 edges a second.
`timescale 1ns/1ps
`default_nettype none

module rtctk_core_tb;
    import rtctk_pkg::*;

    logic clk;
    logic reset;
    logic xtal;
    logic cmp_n;
    logic vdd_low;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic nv_wr;
    logic [RTCTK_CAL_W-1:0] nv_data;
    logic pfo;
    logic trickle;
    logic bak_sel;
    logic [7:0] v;
    int err_total;
    int n_compared;
    // Arbitrary stored calibration value
    localparam logic [RTCTK_CAL_W-1:0] NV_INIT = 6'h23;
    logic [7:0] rst_time [RTCTK_TIME_REGS] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    logic [7:0] set_time [RTCTK_TIME_REGS] = '{8'h58, 8'h59, 8'h23, 8'h07, 8'h29, 8'h02, 8'h24};
    logic [7:0] new_day [RTCTK_TIME_REGS] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h24};
    // Short second so the calendar can roll inside the run
    localparam int XTAL_TB_HZ = 128;

    rtctk_core #(.XTAL_HZ(XTAL_TB_HZ)) uut (.CLK(clk), .RESET(reset), .REG_ADDR(addr),
        .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .XTAL_IN(xtal),
        .POWERFAIL_CMP_N(cmp_n), .VDD_LOW(vdd_low), .NV_CAL_VALUE(NV_INIT),
        .NV_CAL_WR(nv_wr), .NV_CAL_DATA(nv_data), .TUNING_OR_POWERFAIL_OUT(pfo),
        .TRICKLE_CHARGE_ENABLE(trickle), .BACKUP_SUPPLY_SELECT(bak_sel));
    rtctk_host host (.CLK(clk), .REG_RDATA(rdata), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd));

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // ----
    // Helpers
    // ----
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            xtal = 1'h1;
            cyc(4);
            xtal = 1'h0;
            cyc(4);
        end
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, v);
        chk(what, exp, v);
    endtask

    // Time values stay in BCD range before the lock is released
    task automatic put_time();
        for (int i = 0; i < RTCTK_TIME_REGS; i++) begin
            host.wr(RTCTK_OFS_SECONDS + 8'(i), set_time[i]);
        end
    endtask

    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        rc("control", RTCTK_OFS_CONTROL, RTCTK_CONTROL_RST);
        rc("config", RTCTK_OFS_CONFIG, RTCTK_CONFIG_RST);
        rc("calib", RTCTK_OFS_CALIB, {2'h0, NV_INIT});
        host.wr(RTCTK_OFS_CONTROL, 8'h01);
        for (int i = 0; i < RTCTK_TIME_REGS; i++) begin
            rc("time", RTCTK_OFS_SECONDS + 8'(i), rst_time[i]);
        end
        host.wr(RTCTK_OFS_CONTROL, 8'h00);
        $display("reset values done");
    endtask

    task automatic t_lock();
        host.wr(RTCTK_OFS_CONTROL, 8'h02);
        put_time();
        rc("held sec", RTCTK_OFS_SECONDS, set_time[0]);
        host.wr(RTCTK_OFS_CONTROL, 8'h03);
        rc("core sec", RTCTK_OFS_SECONDS, 8'h00);
        host.wr(RTCTK_OFS_CONTROL, 8'h02);
        put_time();
        host.wr(RTCTK_OFS_CONTROL, 8'h00);
        host.wr(RTCTK_OFS_CONTROL, 8'h01);
        for (int i = 0; i < RTCTK_TIME_REGS; i++) begin
            rc("loaded", RTCTK_OFS_SECONDS + 8'(i), set_time[i]);
        end
        host.wr(RTCTK_OFS_CONTROL, 8'h00);
        $display("write lock done");
    endtask

    task automatic t_cal();
        int n;
        logic last;
        host.wr(RTCTK_OFS_CALIB, 8'h21);
        rc("cal gated", RTCTK_OFS_CALIB, {2'h0, NV_INIT});
        host.wr(RTCTK_OFS_CONTROL, 8'h04);
        host.wr(RTCTK_OFS_CALIB, 8'h21);
        rc("cal pos", RTCTK_OFS_CALIB, 8'h21);
        host.wr(RTCTK_OFS_CALIB, 8'h05);
        rc("cal neg", RTCTK_OFS_CALIB, 8'h05);
        chk("nv data", 8'h05, {2'h0, nv_data});
        cyc(8);
        n = 0;
        last = pfo;
        // Comparator toggles too; the tone must ignore it
        // Three tone half periods of 32 edges, short of the divider wrap
        repeat (96) begin
            xtal = 1'h1;
            cyc(4);
            xtal = 1'h0;
            cmp_n = ~cmp_n;
            cyc(4);
            n += int'(pfo !== last);
            last = pfo;
        end
        chk("tone flips", 8'h03, 8'(n));
        host.wr(RTCTK_OFS_CONTROL, 8'h00);
        cmp_n = 1'h0;
        cyc(8);
        chk("pfo low", 8'h00, {7'h00, pfo});
        cmp_n = 1'h1;
        cyc(8);
        chk("pfo high", 8'h01, {7'h00, pfo});
        $display("calibration done");
    endtask

    task automatic t_trickle();
        host.wr(RTCTK_OFS_CONFIG, 8'h04);
        cyc(3);
        chk("trickle on", 8'h01, {7'h00, trickle});
        host.wr(RTCTK_OFS_CONFIG, 8'hFF);
        rc("config", RTCTK_OFS_CONFIG, RTCTK_CONFIG_MASK);
        host.wr(RTCTK_OFS_CONFIG, 8'h00);
        cyc(3);
        chk("trickle off", 8'h00, {7'h00, trickle});
        host.wr(8'h0C, 8'h5A);
        rc("unmapped", 8'h0C, 8'h00);
        $display("trickle done");
    endtask

    task automatic t_backup();
        rc("calib", RTCTK_OFS_CALIB, 8'h05);
        vdd_low = 1'h1;
        cyc(6);
        chk("backup on", 8'h01, {7'h00, bak_sel});
        host.wr(RTCTK_OFS_CONFIG, 8'h04);
        host.rd(RTCTK_OFS_CONTROL, v);
        chk("read refused", 8'h05, v);
        vdd_low = 1'h0;
        cyc(6);
        chk("backup off", 8'h00, {7'h00, bak_sel});
        rc("write refused", RTCTK_OFS_CONFIG, 8'h00);
        $display("backup done");
    endtask

    // Divider stands at 96 after the tone test; with calibration 05 every
    // later second lasts the rate plus 5 skipped edges
    task automatic t_tick();
        host.wr(RTCTK_OFS_CONTROL, 8'h02);
        put_time();
        host.wr(RTCTK_OFS_CONTROL, 8'h00);
        pulses(XTAL_TB_HZ - 96);
        host.wr(RTCTK_OFS_CONTROL, 8'h01);
        pulses(XTAL_TB_HZ + 5);
        rc("frozen sec", RTCTK_OFS_SECONDS, 8'h59);
        host.wr(RTCTK_OFS_CONTROL, 8'h00);
        host.wr(RTCTK_OFS_CONTROL, 8'h01);
        for (int i = 0; i < RTCTK_TIME_REGS; i++) begin
            rc("rollover", RTCTK_OFS_SECONDS + 8'(i), new_day[i]);
        end
        host.wr(RTCTK_OFS_CONTROL, 8'h00);
        pulses(XTAL_TB_HZ + 4);
        host.wr(RTCTK_OFS_CONTROL, 8'h01);
        rc("skipped", RTCTK_OFS_SECONDS, 8'h00);
        host.wr(RTCTK_OFS_CONTROL, 8'h00);
        pulses(1);
        host.wr(RTCTK_OFS_CONTROL, 8'h01);
        rc("tick", RTCTK_OFS_SECONDS, 8'h01);
        host.wr(RTCTK_OFS_CONTROL, 8'h00);
        $display("tick done");
    endtask

    initial begin
        reset = 1'h1;
        xtal = 1'h0;
        cmp_n = 1'h1;
        vdd_low = 1'h0;
        err_total = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        #1;
        reset = 1'h0;
        cyc(2);
        t_reset();
        t_lock();
        t_cal();
        t_trickle();
        t_backup();
        t_tick();
        close_out();
    end

    // Whole run is near 3400 cycles; this is about six times that
    initial begin
        #80000;
        err_total++;
        $display("[FAIL] run expected finish seen hang");
        close_out();
    end
endmodule
`default_nettype wire
